//--- bench/baud_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module baud_link_monitor
    import baud_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdValid,
    input wire logic baudTick
);
    logic kSeen_q;
    logic ctlWr;
    assign ctlWr = wrEn && addr == CONTROL_ADDR;
    // a K of zero leaves the fraction unusable, so only a nonzero write arms it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kSeen_q <= 1'b0;
        end else if (wrEn && addr == ADJUST_ADDR) begin
            kSeen_q <= wdata[3:0] != 4'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_read_answer: assert property (rdEn |=> rdValid)
        else $error("read got no answer");
    chk_valid_cause: assert property (rdValid |-> $past(rdEn))
        else $error("answer without read");
    chk_rdata_hold: assert property (!rdValid |-> $stable(rdata))
        else $error("read data moved");
    chk_adjust_upper: assert property (rdValid && $past(addr) == ADJUST_ADDR |-> rdata[7:4] == 4'h0)
        else $error("adjust upper bits set");
    chk_top_zero: assert property (ctlWr |-> !wdata[TOP_BIT])
        else $error("top control bit written one");
    chk_fraction_legal: assert property (ctlWr && wdata[FEN_BIT] |-> wdata[3:0] != DIV_CODE_16 && wdata[3:0] != DIV_CODE_1)
        else $error("fraction with divisor 16 or 1");
    chk_k_first: assert property (ctlWr && wdata[FEN_BIT] |-> kSeen_q)
        else $error("fraction enabled before K");
    chk_tick_pulse: assert property (baudTick |=> !baudTick)
        else $error("tick longer than a cycle");
    chk_reset_rate: assert property ($rose(rst_n) |-> ##[1:40] baudTick)
        else $error("no tick after reset");
    cover property (ctlWr && wdata[FEN_BIT]);
    cover property (rdValid && $past(addr) == ADJUST_ADDR);
    cover property (baudTick ##2 baudTick);
endmodule
`default_nettype wire

//--- bench/serial_baud_divider_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_baud_divider_tb_top
    import baud_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic uartMode;
    logic bitTick;
    logic bitClk;
    logic fractionActive;
    logic [31:0] rd;
    logic er;
    int c;
    int errCount = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    baud_link_if lnk (.clk(clk), .rst_n(rst_n));
    baud_generator i_baud_generator (.link(lnk.device), .bitTick(bitTick), .bitClk(bitClk),
        .fractionActive(fractionActive));
    baud_host_ctrl i_baud_host_ctrl (.link(lnk.host), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uartMode(uartMode));
    baud_link_monitor i_baud_link_monitor (.clk(clk), .rst_n(rst_n), .wrEn(lnk.wrEn), .rdEn(lnk.rdEn),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .rdValid(lnk.rdValid),
        .baudTick(lnk.baudTick));

    task summarize();
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task timedOut();
        errCount++;
        $display("[ERR] %0t wait ran out", $time);
        summarize();
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            timedOut();
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // control writes are sanitised by the host, so read back what landed
    task wrchk(input logic [7:0] v, input logic [7:0] exp);
        apb(1'b1, CTRL_OFS, {24'h0, v});
        rdchk(CTRL_OFS, {24'h0, exp});
    endtask

    // counts clocks over n tick periods, starting at the next tick
    task meas(input int n, output int cnt);
        int t;
        int g;
        t = -1;
        cnt = 0;
        g = 0;
        while (t < n) begin
            @(posedge clk);
            g++;
            if (t >= 0) begin
                cnt++;
            end
            if (bitTick === 1'b1) begin
                t++;
            end
            if (g > 9000) begin
                timedOut();
            end
        end
    endtask

    // the first periods after a write may mix old and new settings
    task rate(input logic [7:0] ctl, input int n, input int exp);
        apb(1'b1, CTRL_OFS, {24'h0, ctl});
        meas(2, c);
        meas(n, c);
        chk(c, exp);
    endtask

    task tRegs();
        rdchk(CTRL_OFS, 32'h0);
        rdchk(ADJ_OFS, 32'h0);
        rdchk(MODE_OFS, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, MODE_OFS, 32'h1);
        wrchk(8'h45, 8'h05);
        apb(1'b1, ADJ_OFS, 32'hf4);
        rdchk(ADJ_OFS, 32'h04);
        wrchk(8'h45, 8'h45);
        apb(1'b1, MODE_OFS, 32'h0);
        rdchk(CTRL_OFS, 32'h05);
        chk({31'h0, uartMode}, 32'h0);
        apb(1'b1, MODE_OFS, 32'h1);
        chk({31'h0, uartMode}, 32'h1);
        wrchk(8'h41, 8'h01);
        wrchk(8'h40, 8'h00);
        wrchk(8'h01, 8'h01);
        apb(1'b1, MODE_OFS, 32'h0);
        rdchk(CTRL_OFS, 32'h02);
        apb(1'b1, MODE_OFS, 32'h1);
        wrchk(8'h85, 8'h05);
        apb(1'b1, MODE_OFS, 32'h0);
        wrchk(8'hc1, 8'h02);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({31'h0, rd[STAT_ADJUSTED_BIT]}, 32'h1);
        wrchk(8'h45, 8'h05);
    endtask

    task tRates();
        logic lvl;
        apb(1'b1, MODE_OFS, 32'h1);
        rate(8'h03, 1, 6);
        chk({31'h0, fractionActive}, 32'h0);
        // the bit clock level flips once per tick period
        lvl = bitClk;
        meas(0, c);
        chk({31'h0, bitClk}, {31'h0, ~lvl});
        rate(8'h13, 1, 24);
        rate(8'h23, 1, 96);
        rate(8'h33, 1, 384);
        // slow ticks leave no tick between the clear and the first read
        apb(1'b1, STAT_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({16'h0, rd[STAT_COUNT_LSB +: 16]}, 32'h0);
        meas(2, c);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({16'h0, rd[STAT_COUNT_LSB +: 16]}, 32'h3);
        rate(8'h00, 1, 32);
        rate(8'h01, 1, 2);
        rate(8'h43, 16, 120);
        chk({31'h0, fractionActive}, 32'h1);
    endtask

    task tReset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(CTRL_OFS, 32'h0);
        rdchk(ADJ_OFS, 32'h0);
        chk({31'h0, uartMode}, 32'h0);
        chk({31'h0, fractionActive}, 32'h0);
        rate(8'h00, 1, 32);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tRegs();
        tRates();
        tReset();
        summarize();
    end
endmodule
`default_nettype wire

//--- rtl/baud_generator.sv
`timescale 1ns/10ps
`default_nettype none
module baud_generator
    import baud_pkg::*;
(
    baud_link_if.device link,
    output logic bitTick,
    output logic bitClk,
    output logic fractionActive
);
    logic [7:0] control_q;
    logic [7:0] adjust_q;
    logic [7:0] rdata_q;
    logic rdValid_q;
    logic [3:0] tapTick;
    logic [3:0] divCode;
    logic [3:0] kVal;
    logic [1:0] srcSel;
    logic fracOn;
    logic inTick;
    logic wrap;
    logic [4:0] cnt_q;
    logic [4:0] lastIdx;
    logic [3:0] acc_q;
    logic extra_q;
    logic [4:0] accSum;
    logic tick_q;
    logic clk_q;
    logic frac_q;

    prescale_taps i_prescale_taps (
        .clk(link.clk),
        .rst_n(link.rst_n),
        .tapTick(tapTick)
    );

    assign divCode = control_q[DIV_LSB +: 4];
    assign srcSel = control_q[SRC_LSB +: 2];
    assign kVal = adjust_q[K_LSB +: 4];
    // an illegal fraction setting falls back to plain division by N
    assign fracOn = control_q[FEN_BIT] && fractionLegal(divCode, kVal);
    assign inTick = tapTick[srcSel];
    assign lastIdx = divisorN(divCode) - 5'h01 + {4'h0, extra_q};
    assign wrap = inTick && (cnt_q >= lastIdx);
    assign accSum = {1'b0, acc_q} + (FRACTION_BASE - {1'b0, kVal});

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            control_q <= CONTROL_RESET;
            adjust_q <= ADJUST_RESET;
        end else if (link.wrEn) begin
            if (link.addr == CONTROL_ADDR) begin
                control_q <= link.wdata;
            end else if (link.addr == ADJUST_ADDR) begin
                adjust_q <= {4'h0, link.wdata[K_LSB +: 4]};
            end
        end
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            rdata_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= link.rdEn;
            if (link.rdEn) begin
                rdata_q <= (link.addr == CONTROL_ADDR) ? control_q :
                           (link.addr == ADJUST_ADDR) ? adjust_q : 8'h00;
            end
        end
    end

    // >= keeps the count sane when N is lowered mid-period
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            cnt_q <= 5'h00;
        end else if (wrap) begin
            cnt_q <= 5'h00;
        end else if (inTick) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // carry of (16-K)/16 per period stretches 16-K of every 16 periods by one input clock
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            acc_q <= 4'h0;
            extra_q <= 1'b0;
        end else if (!fracOn) begin
            acc_q <= 4'h0;
            extra_q <= 1'b0;
        end else if (wrap) begin
            acc_q <= accSum[3:0];
            extra_q <= accSum[4];
        end
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            tick_q <= 1'b0;
            clk_q <= 1'b0;
            frac_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            frac_q <= fracOn;
            if (wrap) begin
                clk_q <= ~clk_q;
            end
        end
    end

    assign bitTick = tick_q;
    assign bitClk = clk_q;
    assign fractionActive = frac_q;
    assign link.baudTick = tick_q;
    assign link.rdata = rdata_q;
    assign link.rdValid = rdValid_q;
endmodule
`default_nettype wire

//--- rtl/baud_host_ctrl.sv
// What this block and the generator do together
// - clock source code picks tap 0, 2, 8, 32
// - divisor code 0000 means sixteen
// - fraction off: divide selected clock by N
// - fraction on: divide by N+(16-K)/16 average
// - divisor one without fraction only in UART
// - no divisor one with fraction in UART
// - I/O interface mode uses divisor two upward
// - write K before setting fraction enable
// - no fraction with N of 16 or 1
// - fraction enable cleared in I/O interface mode
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module baud_host_ctrl
    import baud_pkg::*;
(
    baud_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic uartMode
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEVICE,
        ST_REPLY
    } host_state_t;

    host_state_t state_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic wrEn_q;
    logic rdEn_q;
    logic [31:0] addr_q;
    logic [7:0] wdata_q;
    logic uart_q;
    logic [3:0] kShadow_q;
    logic adjusted_q;
    logic [15:0] tickCount_q;
    logic request;
    logic isCtrl;
    logic isAdj;
    logic isMode;
    logic isStat;
    logic mapped;
    logic [7:0] ctrlSafe;
    logic [7:0] modeSafe;
    logic [7:0] ctrlShadow_q;

    assign request = psel && penable && (state_q == ST_IDLE);
    assign isCtrl = (paddr == CTRL_OFS);
    assign isAdj = (paddr == ADJ_OFS);
    assign isMode = (paddr == MODE_OFS);
    assign isStat = (paddr == STAT_OFS);
    assign mapped = isCtrl || isAdj || isMode || isStat;

    // a control value is made legal for the given mode and K before it reaches the generator
    function automatic logic [7:0] legalControl(input logic [7:0] raw, input logic uart, input logic [3:0] k);
        logic [3:0] div;
        logic fen;
        div = raw[DIV_LSB +: 4];
        if (!uart && div == DIV_CODE_1) begin
            div = DIV_CODE_2;
        end
        fen = raw[FEN_BIT] && uart;
        if (!fractionLegal(div, k)) begin
            // K still zero means it was not written first
            fen = 1'b0;
        end
        legalControl = 8'h00;
        legalControl[DIV_LSB +: 4] = div;
        legalControl[SRC_LSB +: 2] = raw[SRC_LSB +: 2];
        legalControl[FEN_BIT] = fen;
    endfunction

    assign ctrlSafe = legalControl(pwdata[7:0], uart_q, kShadow_q);
    // a mode change re-judges the last control value under the new mode
    assign modeSafe = legalControl(ctrlShadow_q, pwdata[0], kShadow_q);

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (request) begin
                        state_q <= ((isCtrl || isAdj) && !pwrite) ? ST_DEVICE : ST_REPLY;
                    end
                end
                ST_DEVICE: begin
                    // a device read waits here for the link's answer
                    if (link.rdValid) begin
                        state_q <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            if (request && !((isCtrl || isAdj) && !pwrite)) begin
                pready_q <= 1'b1;
                pslverr_q <= !mapped;
                if (!pwrite && isMode) begin
                    prdata_q <= {31'h00000000, uart_q};
                end else if (!pwrite && isStat) begin
                    prdata_q <= {tickCount_q, 15'h0000, adjusted_q};
                end else begin
                    prdata_q <= 32'h00000000;
                end
            end else if (state_q == ST_DEVICE && link.rdValid) begin
                pready_q <= 1'b1;
                prdata_q <= {24'h000000, link.rdata};
            end
        end
    end

    // device port strobes last one cycle; address and data stay until the next access
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            wrEn_q <= 1'b0;
            rdEn_q <= 1'b0;
            addr_q <= CONTROL_ADDR;
            wdata_q <= 8'h00;
        end else begin
            wrEn_q <= request && pwrite && (isCtrl || isAdj || isMode);
            rdEn_q <= request && !pwrite && (isCtrl || isAdj);
            if (request && (isCtrl || isAdj)) begin
                addr_q <= isCtrl ? CONTROL_ADDR : ADJUST_ADDR;
                wdata_q <= isCtrl ? ctrlSafe : {4'h0, pwdata[K_LSB +: 4]};
            end else if (request && pwrite && isMode) begin
                // a setting legal in one mode may be illegal in the other
                addr_q <= CONTROL_ADDR;
                wdata_q <= modeSafe;
            end
        end
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            ctrlShadow_q <= CONTROL_RESET;
        end else if (request && pwrite && isCtrl) begin
            ctrlShadow_q <= ctrlSafe;
        end else if (request && pwrite && isMode) begin
            ctrlShadow_q <= modeSafe;
        end
    end

    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            kShadow_q <= 4'h0;
            uart_q <= 1'b0;
            adjusted_q <= 1'b0;
        end else if (request && pwrite) begin
            if (isAdj) begin
                kShadow_q <= pwdata[K_LSB +: 4];
            end
            if (isMode) begin
                uart_q <= pwdata[0];
            end
            if (isCtrl) begin
                adjusted_q <= (ctrlSafe != pwdata[7:0]);
            end
        end
    end

    // a tick in the very cycle of a clearing write still counts
    always_ff @(posedge link.clk or negedge link.rst_n) begin
        if (!link.rst_n) begin
            tickCount_q <= 16'h0000;
        end else if (request && pwrite && isStat) begin
            tickCount_q <= {15'h0000, link.baudTick};
        end else if (link.baudTick) begin
            tickCount_q <= tickCount_q + 16'h0001;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign uartMode = uart_q;
    assign link.wrEn = wrEn_q;
    assign link.rdEn = rdEn_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
endmodule
`default_nettype wire

//--- rtl/baud_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface baud_link_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic wrEn;
    logic rdEn;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rdValid;
    logic baudTick;

    modport device (
        input clk,
        input rst_n,
        input wrEn,
        input rdEn,
        input addr,
        input wdata,
        output rdata,
        output rdValid,
        output baudTick
    );

    modport host (
        input clk,
        input rst_n,
        output wrEn,
        output rdEn,
        output addr,
        output wdata,
        input rdata,
        input rdValid,
        input baudTick
    );
endinterface
`default_nettype wire

//--- rtl/baud_pkg.sv
package baud_pkg;

    // device register map, addressed through the device's own port
    localparam logic [31:0] CONTROL_ADDR = 32'hfffff283;
    localparam logic [31:0] ADJUST_ADDR = 32'hfffff284;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] ADJUST_RESET = 8'h00;

    // baud_control fields
    localparam int DIV_LSB = 0;
    localparam int SRC_LSB = 4;
    localparam int FEN_BIT = 6;
    localparam int TOP_BIT = 7;
    // baud_fraction_adjust field
    localparam int K_LSB = 0;

    // clock source codes
    localparam logic [1:0] SRC_TAP_0 = 2'h0;
    localparam logic [1:0] SRC_TAP_2 = 2'h1;
    localparam logic [1:0] SRC_TAP_8 = 2'h2;
    localparam logic [1:0] SRC_TAP_32 = 2'h3;

    // prescaler timing: tap 0 period in system clocks, then each tap is four times the one before
    localparam logic [7:0] TAP0_CYCLES = 8'h02;
    localparam int TAP_COUNT = 4;
    localparam int TAP_STEP_BITS = 2;

    localparam logic [3:0] DIV_CODE_16 = 4'h0;
    localparam logic [3:0] DIV_CODE_1 = 4'h1;
    localparam logic [3:0] DIV_CODE_2 = 4'h2;
    localparam logic [4:0] FRACTION_BASE = 5'h10;

    // controller register map on APB
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ADJ_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam int STAT_ADJUSTED_BIT = 0;
    localparam int STAT_COUNT_LSB = 16;

    // code 0000 stands for a divisor of sixteen
    function automatic logic [4:0] divisorN(input logic [3:0] code);
        divisorN = (code == DIV_CODE_16) ? 5'h10 : {1'b0, code};
    endfunction

    // fraction only applies with K nonzero and N from 2 to 15
    function automatic logic fractionLegal(input logic [3:0] code, input logic [3:0] k);
        fractionLegal = (k != 4'h0) && (code != DIV_CODE_16) && (code != DIV_CODE_1);
    endfunction

endpackage

//--- rtl/prescale_taps.sv
`timescale 1ns/10ps
`default_nettype none
module prescale_taps
    import baud_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output logic [TAP_COUNT-1:0] tapTick
);
    localparam int CHAIN_BITS = TAP_STEP_BITS * (TAP_COUNT - 1);

    logic [7:0] baseCnt_q;
    logic [CHAIN_BITS-1:0] chain_q;
    logic baseTick;

    assign baseTick = (baseCnt_q == TAP0_CYCLES - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baseCnt_q <= 8'h00;
        end else if (baseTick) begin
            baseCnt_q <= 8'h00;
        end else begin
            baseCnt_q <= baseCnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else if (baseTick) begin
            chain_q <= chain_q + CHAIN_BITS'(1);
        end
    end

    // each tap fires once per wrap of its low chain bits, all aligned to the base tick
    assign tapTick[0] = baseTick;
    genvar i;
    generate
        for (i = 1; i < TAP_COUNT; i++) begin : g_tap
            assign tapTick[i] = baseTick && (&chain_q[TAP_STEP_BITS*i-1:0]);
        end
    endgenerate
endmodule
`default_nettype wire
